// ---- modt_pkg.sv ----
// package: instruction classes, opcode decode table and sequencer constants
// Summary of operation
// - add: 28-2F bank, 25 direct, 26-27 indirect, 24 immediate.
// - sum_with_carry_in: 38-3F bank one cycle, 35 and 34 two bytes two cycles.
// - subtract_with_borrow: 98-9F bank one cycle, 95 and 94 two bytes two cycles.
// - bitwise_and_op: 58-5F one cycle, 55 two cycles, 53 three bytes three cycles.
// - bitwise_or_op: 48-4F one cycle, 44 two cycles, 43 three bytes three cycles.
// - bitwise_xor_op: 68-6F one cycle, 64 two cycles, 63 three bytes three cycles.
// - rotates 23, 33, 03, 13 are one byte, one cycle each.
// - nibble swap C4 is one byte taking four cycles.
// - carry bit logic 82, B0, A0, 72 are two bytes, two cycles.
// - carry to bit 92 two bytes three cycles; bit to carry A2 two cycles.
// - data_pointer_16 load 90 is three bytes, three cycles.
// - code_byte_fetch 93 takes seven cycles, 83 takes eight, both one byte.
// - external_ram_move reads E2-E3 5, E0 6; writes F2-F3 4, F0 5 cycles.
// - stack store C0 five cycles, stack load D0 four cycles, two bytes.
// - low_nibble_exchange D6-D7 is one byte taking four cycles.
// - short_relative_jump 80 is two bytes taking four cycles.
// - acc_indexed_jump 73 is one byte taking six cycles.
// - bit branches 10, 20, 30: three bytes, four untaken, six taken.
// - compare_branch_unequal B5, B4, B8-BF, B6-B7: four untaken, six taken.
// - decrement_branch_nonzero D8-DF 2 bytes 3/5; D5 3 bytes 4/6.
// - carry branches 40, 50 take 2/4; acc zero branches 60, 70 take 3/5.
`default_nettype none
package modt_pkg;
  localparam int CYC_W = 4;
  localparam int N_ENTRY = 67;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] UNK_LEN = 2'h1;
  localparam logic [3:0] UNK_CYC = 4'h1;
  localparam logic [7:0] M1 = 8'hFF; // one exact opcode
  localparam logic [7:0] MP = 8'hFE; // indirect_pointer_register pair
  localparam logic [7:0] MB = 8'hF8; // eight bank_register forms

  typedef enum logic [4:0] {
    K_UNKNOWN, K_NO_OPERATION, K_ADD, K_SUMC, K_SUBBOR, K_AND, K_OR, K_XOR,
    K_ROTATE, K_SWAP, K_CBIT, K_BMOVE, K_DPLOAD, K_CODEFETCH, K_XRAM,
    K_STACK, K_NIBXCH, K_JUMP, K_BRANCH
  } modt_class_e;

  // code, mask, class, bytes, untaken cycles, taken cycles
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mask;
    modt_class_e klass;
    logic [1:0] len;
    logic [3:0] cyc_nt;
    logic [3:0] cyc_t;
  } modt_entry_s;

  localparam modt_entry_s DEC_TABLE [N_ENTRY] = '{
    '{8'h28, MB, K_ADD, 2'h1, 4'h1, 4'h1},
    '{8'h25, M1, K_ADD, 2'h2, 4'h2, 4'h2},
    '{8'h26, MP, K_ADD, 2'h1, 4'h2, 4'h2},
    '{8'h24, M1, K_ADD, 2'h2, 4'h2, 4'h2},
    '{8'h38, MB, K_SUMC, 2'h1, 4'h1, 4'h1},
    '{8'h35, M1, K_SUMC, 2'h2, 4'h2, 4'h2},
    '{8'h36, MP, K_SUMC, 2'h1, 4'h2, 4'h2},
    '{8'h34, M1, K_SUMC, 2'h2, 4'h2, 4'h2},
    '{8'h98, MB, K_SUBBOR, 2'h1, 4'h1, 4'h1},
    '{8'h95, M1, K_SUBBOR, 2'h2, 4'h2, 4'h2},
    '{8'h96, MP, K_SUBBOR, 2'h1, 4'h2, 4'h2},
    '{8'h94, M1, K_SUBBOR, 2'h2, 4'h2, 4'h2},
    '{8'h58, MB, K_AND, 2'h1, 4'h1, 4'h1},
    '{8'h55, M1, K_AND, 2'h2, 4'h2, 4'h2},
    '{8'h56, MP, K_AND, 2'h1, 4'h2, 4'h2},
    '{8'h54, M1, K_AND, 2'h2, 4'h2, 4'h2},
    '{8'h52, M1, K_AND, 2'h2, 4'h3, 4'h3},
    '{8'h53, M1, K_AND, 2'h3, 4'h3, 4'h3},
    '{8'h48, MB, K_OR, 2'h1, 4'h1, 4'h1},
    '{8'h45, M1, K_OR, 2'h2, 4'h2, 4'h2},
    '{8'h46, MP, K_OR, 2'h1, 4'h2, 4'h2},
    '{8'h44, M1, K_OR, 2'h2, 4'h2, 4'h2},
    '{8'h42, M1, K_OR, 2'h2, 4'h3, 4'h3},
    '{8'h43, M1, K_OR, 2'h3, 4'h3, 4'h3},
    '{8'h68, MB, K_XOR, 2'h1, 4'h1, 4'h1},
    '{8'h65, M1, K_XOR, 2'h2, 4'h2, 4'h2},
    '{8'h66, MP, K_XOR, 2'h1, 4'h2, 4'h2},
    '{8'h64, M1, K_XOR, 2'h2, 4'h2, 4'h2},
    '{8'h62, M1, K_XOR, 2'h2, 4'h3, 4'h3},
    '{8'h63, M1, K_XOR, 2'h3, 4'h3, 4'h3},
    '{8'h23, M1, K_ROTATE, 2'h1, 4'h1, 4'h1},
    '{8'h33, M1, K_ROTATE, 2'h1, 4'h1, 4'h1},
    '{8'h03, M1, K_ROTATE, 2'h1, 4'h1, 4'h1},
    '{8'h13, M1, K_ROTATE, 2'h1, 4'h1, 4'h1},
    '{8'hC4, M1, K_SWAP, 2'h1, 4'h4, 4'h4},
    '{8'h82, M1, K_CBIT, 2'h2, 4'h2, 4'h2},
    '{8'hB0, M1, K_CBIT, 2'h2, 4'h2, 4'h2},
    '{8'hA0, M1, K_CBIT, 2'h2, 4'h2, 4'h2},
    '{8'h72, M1, K_CBIT, 2'h2, 4'h2, 4'h2},
    '{8'h92, M1, K_BMOVE, 2'h2, 4'h3, 4'h3},
    '{8'hA2, M1, K_BMOVE, 2'h2, 4'h2, 4'h2},
    '{8'h90, M1, K_DPLOAD, 2'h3, 4'h3, 4'h3},
    '{8'h93, M1, K_CODEFETCH, 2'h1, 4'h7, 4'h7},
    '{8'h83, M1, K_CODEFETCH, 2'h1, 4'h8, 4'h8},
    '{8'hE2, MP, K_XRAM, 2'h1, 4'h5, 4'h5},
    '{8'hE0, M1, K_XRAM, 2'h1, 4'h6, 4'h6},
    '{8'hF2, MP, K_XRAM, 2'h1, 4'h4, 4'h4},
    '{8'hF0, M1, K_XRAM, 2'h1, 4'h5, 4'h5},
    '{8'hC0, M1, K_STACK, 2'h2, 4'h5, 4'h5},
    '{8'hD0, M1, K_STACK, 2'h2, 4'h4, 4'h4},
    '{8'hD6, MP, K_NIBXCH, 2'h1, 4'h4, 4'h4},
    '{8'h80, M1, K_JUMP, 2'h2, 4'h4, 4'h4},
    '{8'h73, M1, K_JUMP, 2'h1, 4'h6, 4'h6},
    '{8'h10, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'h20, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'h30, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'hB5, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'hB4, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'hB8, MB, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'hB6, MP, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'hD8, MB, K_BRANCH, 2'h2, 4'h3, 4'h5},
    '{8'hD5, M1, K_BRANCH, 2'h3, 4'h4, 4'h6},
    '{8'h40, M1, K_BRANCH, 2'h2, 4'h2, 4'h4},
    '{8'h50, M1, K_BRANCH, 2'h2, 4'h2, 4'h4},
    '{8'h60, M1, K_BRANCH, 2'h2, 4'h3, 4'h5},
    '{8'h70, M1, K_BRANCH, 2'h2, 4'h3, 4'h5},
    '{8'h00, M1, K_NO_OPERATION, 2'h1, 4'h1, 4'h1}
  };
endpackage
`default_nettype wire

// ---- modt_decode.sv ----
// opcode lookup: class, length and cycle counts of one opcode byte
`timescale 1ns/1ns
`default_nettype none
module modt_decode (
  input wire logic [7:0] op_i,
  output var modt_pkg::modt_class_e klass_o,
  output logic [1:0] len_o,
  output logic [3:0] cyc_nt_o,
  output logic [3:0] cyc_t_o,
  output logic unknown_o
);
  // table search; opcodes not in the table run as one byte, one cycle
  always_comb begin
    klass_o = modt_pkg::K_UNKNOWN;
    len_o = modt_pkg::UNK_LEN;
    cyc_nt_o = modt_pkg::UNK_CYC;
    cyc_t_o = modt_pkg::UNK_CYC;
    unknown_o = 1'b1;
    for (int i = 0; i < modt_pkg::N_ENTRY; i++) begin
      if ((op_i & modt_pkg::DEC_TABLE[i].mask) == modt_pkg::DEC_TABLE[i].code) begin
        klass_o = modt_pkg::DEC_TABLE[i].klass;
        len_o = modt_pkg::DEC_TABLE[i].len;
        cyc_nt_o = modt_pkg::DEC_TABLE[i].cyc_nt;
        cyc_t_o = modt_pkg::DEC_TABLE[i].cyc_t;
        unknown_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- modt_cycle_counter.sv ----
// saturating count of cycles since an instruction's opcode was taken
`timescale 1ns/1ns
`default_nettype none
module modt_cycle_counter #(
  parameter int W = modt_pkg::CYC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic [W-1:0] count_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } modt_cnt_s;

  localparam logic [W-1:0] ONE = W'(1);

  modt_cnt_s s;
  modt_cnt_s next_s;

  // saturates so a long operand stall cannot wrap the count back to zero
  always_comb begin
    next_s = s;
    if (start_i) begin
      next_s.cnt = ONE;
    end else if (s.cnt != '1) begin
      next_s.cnt = s.cnt + ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_o = s.cnt;
endmodule
`default_nettype wire

// ---- modt_sequencer.sv ----
// instruction sequencer: opcode and operand fetch, decode, cycle timing
`timescale 1ns/1ns
`default_nettype none
module modt_sequencer #(
  parameter logic [15:0] PC_START = modt_pkg::PC_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] code_data_i,
  input wire logic code_valid_i,
  input wire logic branch_cond_i,
  output logic code_req_o,
  output logic [15:0] pc_o,
  output logic [7:0] opcode_o,
  output logic [7:0] operand1_o,
  output logic [7:0] operand2_o,
  output var modt_pkg::modt_class_e instr_class_o,
  output logic [1:0] instr_len_o,
  output logic [3:0] instr_cycles_o,
  output logic branch_taken_o,
  output logic unknown_o,
  output logic busy_o,
  output logic instr_done_o
);
  typedef enum logic [1:0] {ST_START, ST_OPCODE, ST_OPERAND, ST_EXEC} modt_state_e;

  typedef struct packed {
    modt_state_e st;
    logic req;
    logic [15:0] pc;
    logic [7:0] op;
    logic [7:0] o1;
    logic [7:0] o2;
    modt_pkg::modt_class_e klass;
    logic [1:0] len;
    logic [1:0] left;
    logic [3:0] cyc_nt;
    logic [3:0] cyc_t;
    logic [3:0] cycles;
    logic cond;
    logic taken;
    logic unk;
    logic busy;
    logic done;
  } modt_seq_s;

  modt_seq_s s;
  modt_seq_s next_s;
  logic accept;
  logic start;
  logic [4:0] elapsed;
  logic [3:0] count;
  modt_pkg::modt_class_e d_klass;
  logic [1:0] d_len;
  logic [3:0] d_nt;
  logic [3:0] d_t;
  logic d_unk;

  modt_decode u_decode (
    .op_i(code_data_i),
    .klass_o(d_klass),
    .len_o(d_len),
    .cyc_nt_o(d_nt),
    .cyc_t_o(d_t),
    .unknown_o(d_unk)
  );

  modt_cycle_counter #(
    .W(modt_pkg::CYC_W)
  ) u_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .count_o(count)
  );

  // fetch, capture and timing; the opcode cycle is cycle 0 of the instruction
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    accept = s.req && code_valid_i;
    start = 1'b0;
    elapsed = {1'b0, count};
    case (s.st)
      ST_START: begin
        next_s.st = ST_OPCODE;
      end
      ST_OPCODE: begin
        elapsed = 5'h00;
        if (accept) begin
          start = 1'b1;
          next_s.st = ST_OPERAND;
          next_s.op = code_data_i;
          next_s.o1 = 8'h00;
          next_s.o2 = 8'h00;
          next_s.klass = d_klass;
          next_s.len = d_len;
          next_s.left = d_len - 2'h1;
          next_s.cyc_nt = d_nt;
          next_s.cyc_t = d_t;
          next_s.cond = d_t != d_nt;
          next_s.taken = 1'b0;
          next_s.unk = d_unk;
        end
      end
      ST_OPERAND: begin
        if (accept) begin
          if (s.left == s.len - 2'h1) begin
            next_s.o1 = code_data_i;
          end else begin
            next_s.o2 = code_data_i;
          end
          next_s.left = s.left - 2'h1;
        end
      end
      default: begin
      end
    endcase
    // every code byte taken moves the program counter on by one
    if (accept) begin
      next_s.pc = s.pc + 16'h0001;
    end
    // branch outcome is sampled with the last byte of the instruction
    if (accept && s.st != ST_START && next_s.left == 2'h0) begin
      next_s.st = ST_EXEC;
      next_s.taken = next_s.cond && branch_cond_i;
    end
    next_s.cycles = next_s.taken ? next_s.cyc_t : next_s.cyc_nt;
    // next opcode only once the documented count has run out
    if (next_s.st == ST_EXEC && (elapsed + 5'h01) >= {1'b0, next_s.cycles}) begin
      next_s.st = ST_OPCODE;
      next_s.done = 1'b1;
    end
    next_s.req = next_s.st == ST_OPCODE || next_s.st == ST_OPERAND;
    next_s.busy = next_s.st == ST_OPERAND || next_s.st == ST_EXEC;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.pc <= PC_START;
    end else begin
      s <= next_s;
    end
  end

  // all outputs come straight from the state register
  assign code_req_o = s.req;
  assign pc_o = s.pc;
  assign opcode_o = s.op;
  assign operand1_o = s.o1;
  assign operand2_o = s.o2;
  assign instr_class_o = s.klass;
  assign instr_len_o = s.len;
  assign instr_cycles_o = s.cycles;
  assign branch_taken_o = s.taken;
  assign unknown_o = s.unk;
  assign busy_o = s.busy;
  assign instr_done_o = s.done;
endmodule
`default_nettype wire

// ---- modt_seq_chk.sv ----
// checker: cycle counts and decode results at the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module modt_seq_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic code_valid_i,
  input wire logic code_req_o,
  input wire logic busy_o,
  input wire logic instr_done_o,
  input wire logic branch_taken_o,
  input wire logic [7:0] opcode_o,
  input wire logic [1:0] instr_len_o,
  input wire logic [3:0] instr_cycles_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] cnt;
  logic take;
  logic dn;
  // an opcode is only ever taken by an idle request
  assign take = code_req_o && code_valid_i && !busy_o;
  assign dn = instr_done_o;
  // cycles since the opcode; saturates so a stalled fetch cannot wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= 4'h0;
    else cnt <= take ? 4'h1 : cnt + 4'(cnt != 4'hF);
  end
  property p_count; dn |-> cnt >= instr_cycles_o; endproperty
  a_count: assert property (p_count) else $error("done early");
  property p_bound; take |-> ##[1:15] dn; endproperty
  a_bound: assert property (p_bound) else $error("no done");
  property p_wait; busy_o && branch_taken_o |-> !code_req_o; endproperty
  a_wait: assert property (p_wait) else $error("fetch while waiting");
  property p_swap; dn && opcode_o == 8'hC4 |-> instr_cycles_o == 4'h4 && instr_len_o == 2'h1;
  endproperty
  a_swap: assert property (p_swap) else $error("swap timing");
  property p_fetch; dn && opcode_o inside {8'h93, 8'h83} |->
    instr_cycles_o == (opcode_o[4] ? 4'h7 : 4'h8); endproperty
  a_fetch: assert property (p_fetch) else $error("code fetch timing");
  property p_xram; dn && opcode_o inside {8'hE0, 8'hE2, 8'hE3} |->
    instr_cycles_o == (opcode_o[1] ? 4'h5 : 4'h6); endproperty
  a_xram: assert property (p_xram) else $error("external read timing");
  property p_carry; dn && opcode_o inside {8'h40, 8'h50} |->
    instr_cycles_o == (branch_taken_o ? 4'h4 : 4'h2); endproperty
  a_carry: assert property (p_carry) else $error("carry branch timing");
  property p_idle; dn && opcode_o == 8'h00 |-> instr_len_o == 2'h1 && instr_cycles_o == 4'h1;
  endproperty
  a_idle: assert property (p_idle) else $error("no operation timing");
  c_taken: cover property (dn && branch_taken_o);
  c_stall: cover property (busy_o && code_req_o && !code_valid_i);
  c_b2b: cover property (take ##1 take);
endmodule
bind modt_sequencer modt_seq_chk u_chk (.clk_i, .rst_i, .code_valid_i, .code_req_o, .busy_o,
  .instr_done_o, .branch_taken_o, .opcode_o, .instr_len_o, .instr_cycles_o);
`default_nettype wire

// ---- modt_prog_mem.sv ----
// program memory model: answers at once up to a fetch limit set by the bench
`timescale 1ns/1ns
`default_nettype none
module modt_prog_mem (
  input wire logic [15:0] addr_i,
  input wire logic req_i,
  input wire logic [15:0] lim_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  logic [7:0] mem [256];
  // past the limit the bus is released: inverted byte, never a stale copy
  assign valid_o = req_i && (addr_i < lim_i);
  assign data_o = valid_o ? mem[addr_i[7:0]] : ~mem[addr_i[7:0]];
endmodule
`default_nettype wire

// ---- tb_mcu_opcode_decode_timing.sv ----
// self-checking bench: opcode lengths, cycle counts and branch timing
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_opcode_decode_timing;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic branch_cond_i = 1'b0;
  logic code_valid_i, code_req_o, busy_o, instr_done_o, branch_taken_o;
  logic [7:0] code_data_i, opcode_o;
  logic [7:0] operand1_o, operand2_o;
  logic unknown_o;
  modt_pkg::modt_class_e instr_class_o;
  logic [15:0] pc_o;
  logic [15:0] lim = 16'h0000;
  logic [15:0] wp = 16'h0000;
  logic [1:0] instr_len_o;
  logic [3:0] instr_cycles_o;
  int err_total = 0;
  int n_checks = 0;
  // 100 MHz clock
  initial forever #5 clk_i = ~clk_i;
  modt_sequencer dut (.clk_i, .rst_i, .code_data_i, .code_valid_i, .branch_cond_i, .code_req_o,
    .pc_o, .opcode_o, .operand1_o, .operand2_o, .instr_class_o, .instr_len_o,
    .instr_cycles_o, .branch_taken_o, .unknown_o, .busy_o, .instr_done_o);
  modt_prog_mem u_mem (.addr_i(pc_o), .req_i(code_req_o), .lim_i(lim), .data_o(code_data_i),
    .valid_o(code_valid_i));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (exp !== got) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one instruction: gap > 0 holds operands back until that cycle
  task automatic run(input logic [7:0] op, input int len, nt, tk, input logic cond, input int gap);
    int n, e, t;
    n = (cond && tk != nt) ? tk : nt;
    e = (len == 1) ? 0 : ((gap > 0) ? gap : 1) + len - 2;
    e = (n > e) ? n : e + 1;
    u_mem.mem[wp[7:0]] = op;
    u_mem.mem[wp[7:0] + 8'h01] = 8'h5A;
    u_mem.mem[wp[7:0] + 8'h02] = 8'hA5;
    lim = wp + 16'((gap > 0) ? 1 : len);
    branch_cond_i = cond;
    @(posedge clk_i iff (code_req_o && code_valid_i && pc_o == wp));
    for (t = 1; t < 20; t++) begin
      #1;
      if (t == gap) lim = wp + 16'(len);
      if (instr_done_o === 1'b1) break;
      @(posedge clk_i);
    end
    chk("cycles_to_done", 16'(e), 16'(t));
    chk("opcode", 16'(op), 16'(opcode_o));
    chk("length", 16'(len), 16'(instr_len_o));
    chk("cycle_count", 16'(n), 16'(instr_cycles_o));
    chk("branch_taken", 16'(cond && tk != nt), 16'(branch_taken_o));
    chk("operand1", (len > 1) ? 16'h005A : 16'h0000, 16'(operand1_o));
    chk("operand2", (len > 2) ? 16'h00A5 : 16'h0000, 16'(operand2_o));
    chk("pc", wp + 16'(len), pc_o);
    chk("busy", 16'h0000, 16'(busy_o));
    wp = wp + 16'(len);
  endtask
  // odd entries run with the condition true
  task automatic many(input logic [7:0] q [$], input int len, nt, tk);
    foreach (q[i]) run(q[i], len, nt, tk, 1'(i % 2), 0);
  endtask
  task automatic t_plain;
    many({8'h28, 8'h2F, 8'h38, 8'h3F, 8'h98, 8'h9F}, 1, 1, 1);
    many({8'h58, 8'h5F, 8'h48, 8'h4F, 8'h68, 8'h6F}, 1, 1, 1);
    many({8'h23, 8'h33, 8'h03, 8'h13, 8'h00, 8'h00}, 1, 1, 1);
    many({8'h25, 8'h24, 8'h35, 8'h34, 8'h95, 8'h94}, 2, 2, 2);
    many({8'h55, 8'h44, 8'h64, 8'hA2}, 2, 2, 2);
    many({8'h82, 8'hB0, 8'hA0, 8'h72}, 2, 2, 2);
    many({8'h26, 8'h27}, 1, 2, 2);
    many({8'h53, 8'h43, 8'h63, 8'h90}, 3, 3, 3);
    many({8'h92}, 2, 3, 3);
  endtask
  task automatic t_long;
    many({8'hC4, 8'hF2, 8'hF3, 8'hD6, 8'hD7}, 1, 4, 4);
    many({8'hE2, 8'hE3, 8'hF0}, 1, 5, 5);
    many({8'hE0, 8'h73}, 1, 6, 6);
    many({8'h93}, 1, 7, 7);
    many({8'h83}, 1, 8, 8);
    many({8'hC0}, 2, 5, 5);
    many({8'hD0, 8'h80}, 2, 4, 4);
  endtask
  // each branch seen untaken then taken; compare branches B5, B4, B8, BF, B6, B7 run once each, alternately untaken and taken
  task automatic t_branch;
    many({8'h10, 8'h10, 8'h20, 8'h20, 8'h30, 8'h30, 8'hD5, 8'hD5}, 3, 4, 6);
    many({8'hB5, 8'hB4, 8'hB8, 8'hBF, 8'hB6, 8'hB7}, 3, 4, 6);
    many({8'hD8, 8'hD8, 8'hDF, 8'hDF}, 2, 3, 5);
    many({8'h40, 8'h40, 8'h50, 8'h50}, 2, 2, 4);
    many({8'h60, 8'h60, 8'h70, 8'h70}, 2, 3, 5);
  endtask
  // late operands: completion follows the last byte, not the count
  task automatic t_slow;
    run(8'h24, 2, 2, 2, 1'b0, 3);
    run(8'h53, 3, 3, 3, 1'b0, 5);
    run(8'h40, 2, 2, 4, 1'b1, 6);
  endtask
  // one-cycle reset in mid-run: outputs return to rest, fetch restarts at the start address
  task automatic t_reset;
    @(posedge clk_i);
    #1 rst_i = 1'b1;
    @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("reset_pc", modt_pkg::PC_RESET, pc_o);
    chk("reset_req", 16'h0000, 16'(code_req_o));
    chk("reset_done", 16'h0000, 16'(instr_done_o));
    chk("reset_opcode", 16'h0000, 16'(opcode_o));
    wp = modt_pkg::PC_RESET;
    run(8'h00, 1, 1, 1, 1'b0, 0);
  endtask
  // an opcode outside the table runs as one byte, one cycle, and is flagged
  task automatic t_odd;
    run(8'hA5, 1, 1, 1, 1'b1, 0);
    chk("unknown", 16'h0001, 16'(unknown_o));
    chk("class", 16'(modt_pkg::K_UNKNOWN), 16'(instr_class_o));
    run(8'hC4, 1, 4, 4, 1'b0, 0);
    chk("unknown", 16'h0000, 16'(unknown_o));
    chk("class", 16'(modt_pkg::K_SWAP), 16'(instr_class_o));
    run(8'h73, 1, 6, 6, 1'b0, 0);
    chk("class", 16'(modt_pkg::K_JUMP), 16'(instr_class_o));
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // about 300 cycles expected; stop a hang well beyond that
  initial begin
    #100000;
    err_total++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_plain;
    t_long;
    t_branch;
    t_slow;
    t_reset;
    t_odd;
    conclude;
  end
endmodule
`default_nettype wire
